// File: include/dup_pkg.sv
// Constants shared by the dual serial controller design.
package dup_pkg;
	// ==========================================
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int BAUD_RATE = 9600;
	localparam int OVERSAMPLE = 16;
	localparam int BAUD_DIV = CLK_HZ / (OVERSAMPLE * BAUD_RATE);
	localparam int FIFO_DEPTH = 8;
	// ==========================================
	// Register addresses
	localparam logic [3:0] A_MR_A = 4'h0;
	localparam logic [3:0] A_SR_A = 4'h1;
	localparam logic [3:0] A_CR_A = 4'h2;
	localparam logic [3:0] A_DATA_A = 4'h3;
	localparam logic [3:0] A_INT = 4'h4;
	localparam logic [3:0] A_OUTPUT_PORT_CONFIG = 4'h5;
	localparam logic [3:0] A_IVR = 4'h6;
	localparam logic [3:0] A_OPR_SET = 4'h7;
	localparam logic [3:0] A_MR_B = 4'h8;
	localparam logic [3:0] A_SR_B = 4'h9;
	localparam logic [3:0] A_CR_B = 4'ha;
	localparam logic [3:0] A_DATA_B = 4'hb;
	localparam logic [3:0] A_OPR_CLR = 4'hc;
	localparam logic [3:0] A_TC_CTL = 4'hd;
	localparam logic [3:0] A_TC_HI = 4'he;
	localparam logic [3:0] A_TC_LO = 4'hf;
	// ==========================================
	// Reset values
	localparam logic [7:0] IVR_RST = 8'h0f;
	localparam logic [7:0] ZERO_RST = 8'h00;
	// ==========================================
	// Field positions
	localparam int CR_RX_EN = 0;
	localparam int CR_RX_DIS = 1;
	localparam int CR_TX_EN = 2;
	localparam int CR_TX_DIS = 3;
	localparam int CR_ERR_RST = 4;
	localparam int CR_PTR_RST = 5;
	localparam int MR1_RX_RTS = 7;
	localparam int MR1_FFULL_SEL = 6;
	localparam int MR2_TX_RTS = 5;
	localparam int MR2_CTS_EN = 4;
	localparam int MR2_RX_EXT = 1;
	localparam int MR2_TX_EXT = 0;
	localparam logic [1:0] MODE_LOCAL_LOOP = 2'h2;
	localparam int TC_RUN = 0;
	localparam int TC_EXT = 1;
	localparam logic [1:0] OP_SEL_GP = 2'h0;
	localparam logic [1:0] OP_SEL_ALT1 = 2'h1;
	localparam logic [1:0] OP_SEL_TX1X = 2'h2;
	localparam logic [1:0] OP_SEL_RX1X = 2'h3;
endpackage

// File: verilog/dup_duart.sv
// Dual serial controller: host bus slave, two channels, timer and multipurpose pins.
// ==========================================
// How it works
// - Data bus released outside select and vector cycles
// - Address lines pick register per access
// - Byte wide bus, bit 0 least significant
// - Reset clears status, masks, output port
// - Reset loads vector register with 0f
// - Reset drives output pins high, halts timer
// - Reset idles channels, marks lines, MR1 pointer
// - Acknowledge driven on read, write, vector
// - Interrupt low when any unmasked condition
// - Vector cycle acknowledged only when pending
// - Receiver takes LSB first, high is mark
// - Transmitter LSB first, mark when quiet
// - Pins 0,1 general or auto request-to-send
// - Pin 2 general or channel A clocks
// - Pin 3 general, timer, or B clocks
// - Pins 4-7 ready or full flags
// - Inputs 0,1 general or clear-to-send
// - Inputs 4,2 receive clocks, rising sample
// - Inputs 3,5 transmit clocks, falling change
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Receive buffer
module dup_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = dup_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q;
	logic push, pop;
	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // dup_fifo

// ==========================================
// One serial channel
module dup_channel (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick16,
	input wire logic ext_rx,
	input wire logic ext_tx,
	input wire logic rxd,
	input wire logic cts_n,
	input wire logic wr_mr,
	input wire logic wr_cr,
	input wire logic wr_thr,
	input wire logic rd_rhr,
	input wire logic [7:0] wdata,
	output logic txd,
	output logic [7:0] mode_rd,
	output logic [7:0] status,
	output logic [7:0] rx_byte,
	output logic rx_flag,
	output logic tx_rdy,
	output logic rts_off,
	output logic tx1x,
	output logic rx1x,
	output logic clk16
);
	typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} dup_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dup_rx_t;
	dup_tx_t tx_st_q;
	dup_rx_t rx_st_q;
	logic [7:0] mr1_q, mr2_q, thr_q, rsh_q;
	logic [8:0] tsh_q;
	logic [3:0] tcnt_q, tsub_q, rcnt_q;
	logic [2:0] rbits_q;
	logic ptr_q, rx_en_q, tx_en_q, thr_full_q, line_q, rx_prev_q, tx_prev_q;
	logic overrun_q, frame_q, push, fifo_ready, rx_avail, empty_prev_q;
	logic loop, rx_line, tx_step, rx_samp, tx_load, tx_empty;

	assign loop = mr2_q[7:6] == dup_pkg::MODE_LOCAL_LOOP;
	assign rx_line = loop ? line_q : rxd;
	assign mode_rd = ptr_q ? mr2_q : mr1_q;
	assign tx_step = mr2_q[dup_pkg::MR2_TX_EXT] ? (tx_prev_q && !ext_tx) : (tick16 && tsub_q == 4'hf);
	assign rx_samp = mr2_q[dup_pkg::MR2_RX_EXT] ? (ext_rx && !rx_prev_q) : (tick16 && rcnt_q == 4'hf);
	assign tx_load = tx_step && tx_st_q == TX_IDLE && thr_full_q && tx_en_q &&
		(!mr2_q[dup_pkg::MR2_CTS_EN] || !cts_n);
	assign tx_rdy = tx_en_q && !thr_full_q;
	assign tx_empty = tx_rdy && tx_st_q == TX_IDLE;
	assign rx_flag = mr1_q[dup_pkg::MR1_FFULL_SEL] ? !fifo_ready : rx_avail;
	assign status = {1'b0, frame_q, 1'b0, overrun_q, tx_empty, tx_rdy, !fifo_ready, rx_avail};
	assign rts_off = (mr1_q[dup_pkg::MR1_RX_RTS] && !fifo_ready) ||
		(mr2_q[dup_pkg::MR2_TX_RTS] && tx_empty && !empty_prev_q);
	assign tx1x = tsub_q[3];
	assign rx1x = rcnt_q[3];

	always_ff @(posedge clk) begin
		if (rst) begin
			mr1_q <= 8'h00;
			mr2_q <= 8'h00;
			ptr_q <= 1'b0;
			rx_en_q <= 1'b0;
			tx_en_q <= 1'b0;
		end else begin
			if (wr_mr) begin
				if (ptr_q) begin
					mr2_q <= wdata;
				end else begin
					mr1_q <= wdata;
				end
			end
			if (wr_cr && wdata[dup_pkg::CR_PTR_RST]) begin
				ptr_q <= 1'b0;
			end else if (wr_mr) begin
				ptr_q <= 1'b1;
			end
			if (wr_cr && (wdata[dup_pkg::CR_RX_EN] || wdata[dup_pkg::CR_RX_DIS])) begin
				rx_en_q <= wdata[dup_pkg::CR_RX_EN];
			end
			if (wr_cr && (wdata[dup_pkg::CR_TX_EN] || wdata[dup_pkg::CR_TX_DIS])) begin
				tx_en_q <= wdata[dup_pkg::CR_TX_EN];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			// Edge detectors start at the pulled-up idle level, so leaving reset makes no false edge.
			rx_prev_q <= 1'b1;
			tx_prev_q <= 1'b1;
			tsub_q <= 4'h0;
			clk16 <= 1'b0;
			empty_prev_q <= 1'b0;
		end else begin
			rx_prev_q <= ext_rx;
			tx_prev_q <= ext_tx;
			empty_prev_q <= tx_empty;
			if (tick16) begin
				tsub_q <= tsub_q + 4'h1;
				clk16 <= !clk16;
			end
		end
	end

	// A write that lands while the holding byte is full is dropped; software polls ready first.
	always_ff @(posedge clk) begin
		if (rst) begin
			thr_q <= 8'h00;
			thr_full_q <= 1'b0;
		end else begin
			if (wr_thr && tx_rdy) begin
				thr_q <= wdata;
			end
			thr_full_q <= (wr_thr && tx_rdy) || (thr_full_q && !tx_load);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_st_q <= TX_IDLE;
			tsh_q <= 9'h1ff;
			tcnt_q <= 4'h0;
			line_q <= 1'b1;
			txd <= 1'b1;
		end else begin
			txd <= loop ? 1'b1 : line_q;
			if (tx_load) begin
				line_q <= 1'b0;
				tsh_q <= {1'b1, thr_q};
				tcnt_q <= 4'h9;
				tx_st_q <= TX_SHIFT;
			end else if (tx_step && tx_st_q == TX_SHIFT) begin
				if (tcnt_q == 4'h0) begin
					tx_st_q <= TX_IDLE;
				end else begin
					line_q <= tsh_q[0];
					tsh_q <= {1'b1, tsh_q[8:1]};
					tcnt_q <= tcnt_q - 4'h1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rx_st_q <= RX_IDLE;
			rcnt_q <= 4'h0;
			rbits_q <= 3'h0;
			rsh_q <= 8'h00;
			push <= 1'b0;
		end else begin
			push <= 1'b0;
			if (tick16 && rx_st_q != RX_IDLE) begin
				rcnt_q <= rcnt_q + 4'h1;
			end
			unique case (rx_st_q)
				RX_IDLE: begin
					rbits_q <= 3'h0;
					if (rx_en_q && !rx_line) begin
						if (!mr2_q[dup_pkg::MR2_RX_EXT]) begin
							rx_st_q <= RX_START;
							rcnt_q <= 4'h0;
						end else if (rx_samp) begin
							rx_st_q <= RX_DATA;
						end
					end
				end
				RX_START: begin
					if (tick16 && rcnt_q == 4'h7) begin
						rcnt_q <= 4'h0;
						rx_st_q <= rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_samp) begin
						rsh_q <= {rx_line, rsh_q[7:1]};
						rbits_q <= rbits_q + 3'h1;
						if (rbits_q == 3'h7) begin
							rx_st_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_samp) begin
						push <= 1'b1;
						rx_st_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// Error flags: a new error in the clearing cycle survives the clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			overrun_q <= 1'b0;
			frame_q <= 1'b0;
		end else begin
			overrun_q <= (push && !fifo_ready) || (overrun_q && !(wr_cr && wdata[dup_pkg::CR_ERR_RST]));
			frame_q <= (rx_st_q == RX_STOP && rx_samp && !rx_line) ||
				(frame_q && !(wr_cr && wdata[dup_pkg::CR_ERR_RST]));
		end
	end

	dup_fifo #(.WIDTH(8), .DEPTH(dup_pkg::FIFO_DEPTH)) u_rx_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push),
		.in_data(rsh_q),
		.in_ready(fifo_ready),
		.out_valid(rx_avail),
		.out_data(rx_byte),
		.out_ready(rd_rhr)
	);
endmodule // dup_channel

// ==========================================
// Top level
module dup_duart #(
	parameter int BAUD_DIV = dup_pkg::BAUD_DIV
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CHIP_SELECT_N,
	input wire logic READ_NOT_WRITE,
	input wire logic [3:0] REGISTER_ADDRESS_LINES,
	input wire logic [7:0] HOST_DATA_BUS_IN,
	output logic [7:0] HOST_DATA_BUS_OUT,
	output logic HOST_DATA_BUS_OE_N,
	output logic TRANSFER_ACK_N,
	output logic TRANSFER_ACK_OE_N,
	output logic INTERRUPT_REQUEST_N,
	output logic INTERRUPT_REQUEST_OE_N,
	input wire logic INTERRUPT_ACK_N,
	input wire logic SERIAL_IN_A,
	input wire logic SERIAL_IN_B,
	output logic SERIAL_OUT_A,
	output logic SERIAL_OUT_B,
	input wire logic [5:0] INPUT_PINS,
	output logic [7:0] OUTPUT_PORT_PINS,
	output logic [7:0] OUTPUT_PORT_OE_N
);
	initial if (BAUD_DIV < 1 || BAUD_DIV > 65535) $error("BAUD_DIV out of range");
	typedef enum logic [0:0] {BUS_IDLE, BUS_HOLD} dup_bus_t;
	dup_bus_t bus_q;
	logic [15:0] div_q, tc_cnt_q, tc_reload_q;
	logic [7:0] imr_q, opr_q, output_port_config_q, ivr_q, interrupt_status, rd_mux, mr_a, mr_b, sr_a, sr_b, rx_a, rx_b, op_d, od_sel;
	logic [1:0] tc_ctl_q;
	logic tick16_q, tc_out_q, tc_done_q, ip2_prev_q, tc_step;
	logic start, acc, wr, rd, rxf_a, rxf_b, txr_a, txr_b, rts_a, rts_b;
	logic t1_a, r1_a, c16_a, t1_b, r1_b, c16_b;

	assign start = bus_q == BUS_IDLE && (!CHIP_SELECT_N || !INTERRUPT_ACK_N);
	assign acc = start && !CHIP_SELECT_N;
	assign wr = acc && !READ_NOT_WRITE;
	assign rd = acc && READ_NOT_WRITE;
	assign interrupt_status = {4'h0, tc_done_q, 1'b0, 1'b0, 1'b0} | {2'b00, rxf_b, txr_b, 2'b00, rxf_a, txr_a};

	always_comb begin
		unique case (REGISTER_ADDRESS_LINES)
			dup_pkg::A_MR_A: rd_mux = mr_a;
			dup_pkg::A_SR_A: rd_mux = sr_a;
			dup_pkg::A_DATA_A: rd_mux = rx_a;
			dup_pkg::A_INT: rd_mux = interrupt_status;
			dup_pkg::A_OUTPUT_PORT_CONFIG: rd_mux = output_port_config_q;
			dup_pkg::A_IVR: rd_mux = ivr_q;
			dup_pkg::A_OPR_SET: rd_mux = {2'b00, INPUT_PINS};
			dup_pkg::A_MR_B: rd_mux = mr_b;
			dup_pkg::A_SR_B: rd_mux = sr_b;
			dup_pkg::A_DATA_B: rd_mux = rx_b;
			dup_pkg::A_TC_HI: rd_mux = tc_cnt_q[15:8];
			dup_pkg::A_TC_LO: rd_mux = tc_cnt_q[7:0];
			default: rd_mux = 8'h00;
		endcase
	end

	// Bus answers one clock after select and holds until both select and acknowledge rise.
	always_ff @(posedge CLK) begin
		if (RST) begin
			bus_q <= BUS_IDLE;
			HOST_DATA_BUS_OUT <= 8'h00;
			HOST_DATA_BUS_OE_N <= 1'b1;
			TRANSFER_ACK_N <= 1'b1;
			TRANSFER_ACK_OE_N <= 1'b1;
		end else if (start) begin
			bus_q <= BUS_HOLD;
			HOST_DATA_BUS_OUT <= acc ? rd_mux : ivr_q;
			HOST_DATA_BUS_OE_N <= !(rd || !acc);
			TRANSFER_ACK_N <= !(acc || INTERRUPT_REQUEST_OE_N == 1'b0);
			TRANSFER_ACK_OE_N <= 1'b0;
		end else if (bus_q == BUS_HOLD && CHIP_SELECT_N && INTERRUPT_ACK_N) begin
			bus_q <= BUS_IDLE;
			HOST_DATA_BUS_OE_N <= 1'b1;
			TRANSFER_ACK_N <= 1'b1;
			TRANSFER_ACK_OE_N <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			imr_q <= dup_pkg::ZERO_RST;
			output_port_config_q <= dup_pkg::ZERO_RST;
			opr_q <= dup_pkg::ZERO_RST;
			ivr_q <= dup_pkg::IVR_RST;
			tc_ctl_q <= 2'b00;
			tc_reload_q <= 16'h0000;
		end else begin
			if (wr && REGISTER_ADDRESS_LINES == dup_pkg::A_INT) imr_q <= HOST_DATA_BUS_IN;
			if (wr && REGISTER_ADDRESS_LINES == dup_pkg::A_OUTPUT_PORT_CONFIG) output_port_config_q <= HOST_DATA_BUS_IN;
			if (wr && REGISTER_ADDRESS_LINES == dup_pkg::A_IVR) ivr_q <= HOST_DATA_BUS_IN;
			if (wr && REGISTER_ADDRESS_LINES == dup_pkg::A_TC_CTL) tc_ctl_q <= HOST_DATA_BUS_IN[1:0];
			if (wr && REGISTER_ADDRESS_LINES == dup_pkg::A_TC_HI) tc_reload_q[15:8] <= HOST_DATA_BUS_IN;
			if (wr && REGISTER_ADDRESS_LINES == dup_pkg::A_TC_LO) tc_reload_q[7:0] <= HOST_DATA_BUS_IN;
			opr_q <= (opr_q & ~{6'h00, rts_b, rts_a}
				| ((wr && REGISTER_ADDRESS_LINES == dup_pkg::A_OPR_SET) ? HOST_DATA_BUS_IN : 8'h00))
				& ~((wr && REGISTER_ADDRESS_LINES == dup_pkg::A_OPR_CLR) ? HOST_DATA_BUS_IN : 8'h00);
		end
	end

	// Baud divider and counter/timer; the timer flag is cleared by any write to the timer control register.
	assign tc_step = tc_ctl_q[dup_pkg::TC_EXT] ? (INPUT_PINS[2] && !ip2_prev_q) : tick16_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			div_q <= 16'h0000;
			tick16_q <= 1'b0;
			ip2_prev_q <= 1'b1;
			tc_cnt_q <= 16'h0000;
			tc_out_q <= 1'b1;
			tc_done_q <= 1'b0;
		end else begin
			ip2_prev_q <= INPUT_PINS[2];
			tick16_q <= div_q == 16'(BAUD_DIV - 1);
			div_q <= (div_q == 16'(BAUD_DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
			if (tc_ctl_q[dup_pkg::TC_RUN] && tc_step) begin
				tc_cnt_q <= (tc_cnt_q == 16'h0000) ? tc_reload_q : tc_cnt_q - 16'h0001;
				if (tc_cnt_q == 16'h0000) tc_out_q <= !tc_out_q;
			end
			tc_done_q <= (tc_ctl_q[dup_pkg::TC_RUN] && tc_step && tc_cnt_q == 16'h0000) ||
				(tc_done_q && !(wr && REGISTER_ADDRESS_LINES == dup_pkg::A_TC_CTL));
		end
	end

	// Output pin selection; open-drain functions only pull low.
	always_comb begin
		op_d = ~opr_q;
		od_sel = {output_port_config_q[7:4], 4'h0};
		unique case (output_port_config_q[1:0])
			dup_pkg::OP_SEL_GP: op_d[2] = ~opr_q[2];
			dup_pkg::OP_SEL_ALT1: op_d[2] = c16_a;
			dup_pkg::OP_SEL_TX1X: op_d[2] = t1_a;
			dup_pkg::OP_SEL_RX1X: op_d[2] = r1_a;
		endcase
		unique case (output_port_config_q[3:2])
			dup_pkg::OP_SEL_GP: op_d[3] = ~opr_q[3];
			dup_pkg::OP_SEL_ALT1: op_d[3] = tc_out_q;
			dup_pkg::OP_SEL_TX1X: op_d[3] = t1_b;
			dup_pkg::OP_SEL_RX1X: op_d[3] = r1_b;
		endcase
		od_sel[3] = output_port_config_q[3:2] == dup_pkg::OP_SEL_ALT1;
		if (output_port_config_q[4]) op_d[4] = !rxf_a;
		if (output_port_config_q[5]) op_d[5] = !rxf_b;
		if (output_port_config_q[6]) op_d[6] = !txr_a;
		if (output_port_config_q[7]) op_d[7] = !txr_b;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			OUTPUT_PORT_PINS <= 8'hff;
			OUTPUT_PORT_OE_N <= 8'h00;
			INTERRUPT_REQUEST_N <= 1'b0;
			INTERRUPT_REQUEST_OE_N <= 1'b1;
		end else begin
			OUTPUT_PORT_PINS <= op_d;
			OUTPUT_PORT_OE_N <= od_sel & op_d;
			INTERRUPT_REQUEST_OE_N <= (interrupt_status & imr_q) == 8'h00;
		end
	end

	dup_channel u_chan_a (
		.clk(CLK), .rst(RST), .tick16(tick16_q), .ext_rx(INPUT_PINS[4]), .ext_tx(INPUT_PINS[3]),
		.rxd(SERIAL_IN_A), .cts_n(INPUT_PINS[0]),
		.wr_mr(wr && REGISTER_ADDRESS_LINES == dup_pkg::A_MR_A),
		.wr_cr(wr && REGISTER_ADDRESS_LINES == dup_pkg::A_CR_A),
		.wr_thr(wr && REGISTER_ADDRESS_LINES == dup_pkg::A_DATA_A),
		.rd_rhr(rd && REGISTER_ADDRESS_LINES == dup_pkg::A_DATA_A),
		.wdata(HOST_DATA_BUS_IN), .txd(SERIAL_OUT_A), .mode_rd(mr_a), .status(sr_a), .rx_byte(rx_a),
		.rx_flag(rxf_a), .tx_rdy(txr_a), .rts_off(rts_a), .tx1x(t1_a), .rx1x(r1_a), .clk16(c16_a)
	);
	dup_channel u_chan_b (
		.clk(CLK), .rst(RST), .tick16(tick16_q), .ext_rx(INPUT_PINS[2]), .ext_tx(INPUT_PINS[5]),
		.rxd(SERIAL_IN_B), .cts_n(INPUT_PINS[1]),
		.wr_mr(wr && REGISTER_ADDRESS_LINES == dup_pkg::A_MR_B),
		.wr_cr(wr && REGISTER_ADDRESS_LINES == dup_pkg::A_CR_B),
		.wr_thr(wr && REGISTER_ADDRESS_LINES == dup_pkg::A_DATA_B),
		.rd_rhr(rd && REGISTER_ADDRESS_LINES == dup_pkg::A_DATA_B),
		.wdata(HOST_DATA_BUS_IN), .txd(SERIAL_OUT_B), .mode_rd(mr_b), .status(sr_b), .rx_byte(rx_b),
		.rx_flag(rxf_b), .tx_rdy(txr_b), .rts_off(rts_b), .tx1x(t1_b), .rx1x(r1_b), .clk16(c16_b)
	);
endmodule // dup_duart
`default_nettype wire

// File: dv/dup_props.sv
// Pin-level assertions for the dual serial controller.
`timescale 1ns/1ps
`default_nettype none
module dup_props #(
	parameter int BAUD_DIV = dup_pkg::BAUD_DIV
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CHIP_SELECT_N,
	input wire logic READ_NOT_WRITE,
	input wire logic [3:0] REGISTER_ADDRESS_LINES,
	input wire logic [7:0] HOST_DATA_BUS_IN,
	input wire logic [7:0] HOST_DATA_BUS_OUT,
	input wire logic HOST_DATA_BUS_OE_N,
	input wire logic TRANSFER_ACK_N,
	input wire logic TRANSFER_ACK_OE_N,
	input wire logic INTERRUPT_REQUEST_N,
	input wire logic INTERRUPT_REQUEST_OE_N,
	input wire logic INTERRUPT_ACK_N,
	input wire logic SERIAL_IN_A,
	input wire logic SERIAL_IN_B,
	input wire logic SERIAL_OUT_A,
	input wire logic SERIAL_OUT_B,
	input wire logic [5:0] INPUT_PINS,
	input wire logic [7:0] OUTPUT_PORT_PINS,
	input wire logic [7:0] OUTPUT_PORT_OE_N
);
	localparam int BIT = 16 * BAUD_DIV;
	// ==========================================
	// Helpers
	// Length of the current low run on the channel A line, in clocks.
	logic [15:0] low_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			low_q <= 16'h0000;
		end else begin
			low_q <= SERIAL_OUT_A ? 16'h0000 : low_q + 16'h0001;
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	sequence sel_s;
		$fell(CHIP_SELECT_N) && TRANSFER_ACK_OE_N;
	endsequence
	sequence vec_s;
		$fell(INTERRUPT_ACK_N) && CHIP_SELECT_N && TRANSFER_ACK_OE_N;
	endsequence
	// ==========================================
	// Assertions
	sel_ack_a: assert property (sel_s |=> !TRANSFER_ACK_N && !TRANSFER_ACK_OE_N)
		else $error("no acknowledge one cycle after select");
	rd_drive_a: assert property (sel_s ##0 READ_NOT_WRITE |=> !HOST_DATA_BUS_OE_N)
		else $error("read cycle did not drive the data bus");
	wr_float_a: assert property (sel_s ##0 !READ_NOT_WRITE |=> HOST_DATA_BUS_OE_N)
		else $error("write cycle drove the data bus");
	bus_release_a: assert property ((CHIP_SELECT_N && INTERRUPT_ACK_N) [*2] |-> HOST_DATA_BUS_OE_N && TRANSFER_ACK_OE_N)
		else $error("bus not released after deselect");
	ack_hold_a: assert property (!TRANSFER_ACK_OE_N && !CHIP_SELECT_N |=> !TRANSFER_ACK_OE_N)
		else $error("acknowledge dropped while selected");
	vec_refuse_a: assert property (vec_s ##0 INTERRUPT_REQUEST_OE_N |=> TRANSFER_ACK_N && !HOST_DATA_BUS_OE_N)
		else $error("vector cycle acknowledged with nothing pending");
	vec_grant_a: assert property (vec_s ##0 !INTERRUPT_REQUEST_OE_N |=> !TRANSFER_ACK_N && !HOST_DATA_BUS_OE_N)
		else $error("pending vector cycle not acknowledged");
	reset_pins_a: assert property (disable iff (1'b0) RST |=> OUTPUT_PORT_PINS == 8'hff && OUTPUT_PORT_OE_N == 8'h00
		&& SERIAL_OUT_A && SERIAL_OUT_B && INTERRUPT_REQUEST_OE_N && HOST_DATA_BUS_OE_N)
		else $error("pins not at reset levels");
	tx_frame_a: assert property ($rose(SERIAL_OUT_A) |-> int'(low_q) % BIT == 0 && int'(low_q) <= 9 * BIT)
		else $error("low run on serial line not whole bits");
	// ==========================================
	// Coverage
	rd_c: cover property (sel_s ##0 READ_NOT_WRITE);
	vec_c: cover property (vec_s ##0 !INTERRUPT_REQUEST_OE_N);
	tx_c: cover property ($rose(SERIAL_OUT_A));
endmodule // dup_props
bind dup_duart dup_props #(.BAUD_DIV(BAUD_DIV)) dup_props_u (.CLK(CLK), .RST(RST),
	.CHIP_SELECT_N(CHIP_SELECT_N), .READ_NOT_WRITE(READ_NOT_WRITE),
	.REGISTER_ADDRESS_LINES(REGISTER_ADDRESS_LINES), .HOST_DATA_BUS_IN(HOST_DATA_BUS_IN),
	.HOST_DATA_BUS_OUT(HOST_DATA_BUS_OUT), .HOST_DATA_BUS_OE_N(HOST_DATA_BUS_OE_N),
	.TRANSFER_ACK_N(TRANSFER_ACK_N), .TRANSFER_ACK_OE_N(TRANSFER_ACK_OE_N),
	.INTERRUPT_REQUEST_N(INTERRUPT_REQUEST_N), .INTERRUPT_REQUEST_OE_N(INTERRUPT_REQUEST_OE_N),
	.INTERRUPT_ACK_N(INTERRUPT_ACK_N), .SERIAL_IN_A(SERIAL_IN_A), .SERIAL_IN_B(SERIAL_IN_B),
	.SERIAL_OUT_A(SERIAL_OUT_A), .SERIAL_OUT_B(SERIAL_OUT_B), .INPUT_PINS(INPUT_PINS),
	.OUTPUT_PORT_PINS(OUTPUT_PORT_PINS), .OUTPUT_PORT_OE_N(OUTPUT_PORT_OE_N));
`default_nettype wire

// File: dv/dup_host.sv
// Host processor model for the controller's parallel bus.
`timescale 1ns/1ps
`default_nettype none
module dup_host (
	input wire logic clk,
	output logic cs_n,
	output logic rnw,
	output logic [3:0] addr,
	output logic [7:0] din,
	output logic iack_n,
	input wire logic [7:0] dout,
	input wire logic doe_n,
	input wire logic ack_n,
	input wire logic ack_oe_n
);
	logic drv = 1'b0;
	logic junk = 1'b0;
	logic [7:0] wd = 8'h00;
	int timeouts = 0;
	initial begin
		cs_n = 1'b1;
		iack_n = 1'b1;
		rnw = 1'b1;
		addr = 4'h0;
	end
	// ==========================================
	// Bus wire
	// An undriven bus toggles every cycle so a stale byte is never mistaken for data.
	always @(posedge clk) junk <= ~junk;
	assign din = !doe_n ? dout : (drv ? wd : {8{junk}});
	// ==========================================
	// One access or vector cycle, held until the device answers.
	task cycle(input logic vec, input logic r, input logic [3:0] a, input logic [7:0] w,
		output logic [7:0] d, output logic ak);
		int n;
		@(posedge clk);
		#1;
		rnw = r;
		addr = a;
		wd = w;
		drv = !r && !vec;
		if (vec) begin
			iack_n = 1'b0;
		end else begin
			cs_n = 1'b0;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (ack_oe_n !== 1'b0 && n < 16);
		if (n == 16) timeouts++;
		@(posedge clk);
		d = dout;
		ak = ack_n;
		#1;
		cs_n = 1'b1;
		iack_n = 1'b1;
		drv = 1'b0;
		repeat (2) @(posedge clk);
	endtask
endmodule // dup_host
`default_nettype wire

// File: dv/tb.sv
// Self-checking testbench for the dual serial controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int BD = 3;
	localparam int BIT = 16 * BD;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic cs_n, rnw, iack_n, doe_n, ack_n, ack_oe_n, int_n, int_oe_n, txa, txb;
	logic [3:0] addr;
	logic [7:0] din, dout, op, op_oe_n, rd, v;
	logic ak;
	logic [5:0] ip = 6'h3f;
	int error_cnt = 0;
	int compares = 0;
	always #10 CLK = ~CLK;
	dup_host host_u (.clk(CLK), .cs_n(cs_n), .rnw(rnw), .addr(addr), .din(din), .iack_n(iack_n),
		.dout(dout), .doe_n(doe_n), .ack_n(ack_n), .ack_oe_n(ack_oe_n));
	// Channel A transmit loops into channel B receive and back.
	dup_duart #(.BAUD_DIV(BD)) dut_u (.CLK(CLK), .RST(RST), .CHIP_SELECT_N(cs_n),
		.READ_NOT_WRITE(rnw), .REGISTER_ADDRESS_LINES(addr), .HOST_DATA_BUS_IN(din),
		.HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE_N(doe_n), .TRANSFER_ACK_N(ack_n),
		.TRANSFER_ACK_OE_N(ack_oe_n), .INTERRUPT_REQUEST_N(int_n), .INTERRUPT_REQUEST_OE_N(int_oe_n),
		.INTERRUPT_ACK_N(iack_n), .SERIAL_IN_A(txb), .SERIAL_IN_B(txa), .SERIAL_OUT_A(txa),
		.SERIAL_OUT_B(txb), .INPUT_PINS(ip), .OUTPUT_PORT_PINS(op), .OUTPUT_PORT_OE_N(op_oe_n));
	// ==========================================
	// Tasks
	task finish_test();
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task acc(input logic vec, input logic r, input logic [3:0] a, input logic [7:0] w);
		host_u.cycle(vec, r, a, w, rd, ak);
		if (host_u.timeouts != 0) begin
			error_cnt++;
			finish_test();
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] w);
		acc(1'b0, 1'b0, a, w);
	endtask
	task rdc(input logic [3:0] a, input logic [7:0] exp);
		acc(1'b0, 1'b1, a, 8'h00);
		check(rd, exp);
	endtask
	// Samples each bit of one frame on channel A at its middle.
	task get_frame();
		int n;
		n = 0;
		while (txa !== 1'b0 && n < 2000) begin
			@(posedge CLK);
			#1;
			n++;
		end
		if (n == 2000) begin
			error_cnt++;
			finish_test();
		end
		repeat (BIT / 2) @(posedge CLK);
		check(txa, 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge CLK);
			v[i] = txa;
		end
		repeat (BIT) @(posedge CLK);
		check(txa, 1'b1);
	endtask
	// ==========================================
	// Sequence
	initial begin
		repeat (100000) @(posedge CLK);
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge CLK);
		#1;
		RST = 1'b0;
		check(op, 8'hff);
		check(op_oe_n, 8'h00);
		check({txa, txb, int_oe_n}, 8'h07);
		rdc(dup_pkg::A_IVR, dup_pkg::IVR_RST);
		rdc(dup_pkg::A_SR_A, 8'h00);
		rdc(dup_pkg::A_SR_B, 8'h00);
		rdc(dup_pkg::A_INT, 8'h00);
		rdc(dup_pkg::A_OUTPUT_PORT_CONFIG, 8'h00);
		rdc(dup_pkg::A_OPR_SET, 8'h3f);
		wr(dup_pkg::A_IVR, 8'ha5);
		rdc(dup_pkg::A_IVR, 8'ha5);
		wr(dup_pkg::A_OPR_SET, 8'h81);
		check(op, 8'h7e);
		wr(dup_pkg::A_OPR_CLR, 8'h80);
		check(op, 8'hfe);
		acc(1'b1, 1'b1, 4'h0, 8'h00);
		check({7'h00, ak}, 8'h01);
		check(rd, 8'ha5);
		wr(dup_pkg::A_CR_A, 8'h04);
		check(int_oe_n, 1'b1);
		// Pin 6 pulls low for a ready transmitter A; pin 3 shows the idle timer output released.
		wr(dup_pkg::A_OUTPUT_PORT_CONFIG, 8'h44);
		check(op, 8'hbe);
		check(op_oe_n, 8'h08);
		wr(dup_pkg::A_OUTPUT_PORT_CONFIG, 8'h00);
		wr(dup_pkg::A_INT, 8'h01);
		check(int_oe_n, 1'b0);
		acc(1'b1, 1'b1, 4'h0, 8'h00);
		check({7'h00, ak}, 8'h00);
		check(rd, 8'ha5);
		wr(dup_pkg::A_INT, 8'h00);
		check(int_oe_n, 1'b1);
		wr(dup_pkg::A_CR_B, 8'h01);
		// Nine bytes into an eight deep receive buffer: the last one overruns.
		for (int i = 1; i <= 9; i++) begin
			wr(dup_pkg::A_DATA_A, 8'(i));
			get_frame();
			check(v, 8'(i));
		end
		repeat (BIT) @(posedge CLK);
		rdc(dup_pkg::A_SR_B, 8'h13);
		for (int i = 1; i <= 8; i++) begin
			rdc(dup_pkg::A_DATA_B, 8'(i));
		end
		rdc(dup_pkg::A_SR_B, 8'h10);
		#1;
		RST = 1'b1;
		repeat (3) @(posedge CLK);
		#1;
		RST = 1'b0;
		check(op, 8'hff);
		rdc(dup_pkg::A_IVR, dup_pkg::IVR_RST);
		finish_test();
	end
endmodule // tb
`default_nettype wire
